// [usb_endpoint_fifo_access.sv]
// Endpoint FIFO access controller with its per-endpoint FIFO
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ns

// ============================================================
// Synchronous FIFO with valid/ready on both sides
module ep_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0]   cnt;
  } fifo_state_type;

  fifo_state_type   st_q;
  fifo_state_type   st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             push;
  logic             pop;

  // Flush blocks both sides for its cycle
  assign in_ready_o  = (st_q.cnt != (PW+1)'(DEPTH)) && !flush_i;
  assign out_valid_o = (st_q.cnt != '0) && !flush_i;
  assign out_data_o  = mem_q[st_q.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb begin
    st_d = st_q;
    if (flush_i) begin
      st_d = '0;
    end else begin
      if (push) st_d.wr = st_q.wr + 1'b1;
      if (pop) st_d.rd = st_q.rd + 1'b1;
      st_d.cnt = st_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (rst_i) st_q <= '0;
    else st_q <= st_d;
  end

  // Storage, written only on an accepted push
  // No reset here; the count alone says which words are valid
  always_ff @(posedge clock_i) begin
    if (push) mem_q[st_q.wr] <= in_data_i;
  end

  // Count never passes the depth, so ready stays honest
  chk_fifo_count_range: assert property (
    @(posedge clock_i) disable iff (rst_i)
    st_q.cnt <= (PW+1)'(DEPTH))
    else $error("endpoint FIFO count above depth");

endmodule : ep_byte_fifo

// ============================================================
// Access controller: Avalon-MM slave plus three endpoint FIFOs
module usb_endpoint_fifo_access #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                           clock_i,
  input  wire logic                           rst_i,
  input  wire logic [usb_fifo_pkg::ADDR_W-1:0] address_i,
  input  wire logic                           read_i,
  input  wire logic                           write_i,
  input  wire logic [31:0]                    writedata_i,
  output logic      [31:0]                    readdata_o,
  output logic                                waitrequest_o,
  input  wire logic                           usb_reset_i,
  input  wire logic                           setup_event_i,
  input  wire logic                           zero_len_event_i,
  input  wire usb_fifo_pkg::stream_type [2:0]  eng_push_i,
  output logic      [2:0]                     eng_push_ready_o,
  output usb_fifo_pkg::stream_type      [2:0]  eng_pop_o,
  input  wire logic [2:0]                     eng_pop_ready_i
);
  localparam int NEP = usb_fifo_pkg::NUM_EP;
  localparam int GAP = usb_fifo_pkg::GAP_CYCLES;

  usb_fifo_pkg::ctrl_state_type st_q;
  usb_fifo_pkg::ctrl_state_type st_d;
  logic [NEP-1:0]        f_in_ready;
  logic [NEP-1:0]        f_out_valid;
  logic [WIDTH-1:0]      f_out_data [NEP];
  logic [NEP-1:0]        fw_push;
  logic [NEP-1:0]        fw_pop;
  logic [NEP-1:0]        own_push;
  logic [NEP-1:0]        own_pop;
  logic [NEP-1:0]        flush;
  logic [NEP-1:0]        port_hit;
  logic                  bus_req;
  logic                  fire;
  logic                  ctrl_hit;
  logic                  any_port;
  logic                  sel_ok;
  logic                  ready;
  logic                  ok;
  logic [7:0]            status;
  logic [7:0]            wd;
  logic [7:0]            head;

  // ==========================================================
  // Bus decode; one wait cycle, then the answer
  // Read data freeze at the taking edge, so a pop on the
  // answering edge cannot change what the master takes
  assign bus_req       = read_i || write_i;
  assign waitrequest_o = bus_req && !st_q.resp;
  assign fire          = bus_req && st_q.resp;
  assign readdata_o    = {24'h000000, st_q.rdata};
  assign ctrl_hit      = address_i == usb_fifo_pkg::CTRL_ADDR;
  assign wd            = writedata_i[7:0];
  assign any_port      = |port_hit;

  // Data port address decode, one per endpoint
  assign port_hit[0] = address_i == {usb_fifo_pkg::PORT0_IDX, 2'b00};
  assign port_hit[1] = address_i == {usb_fifo_pkg::PORT1_IDX, 2'b00};
  assign port_hit[2] = address_i == {usb_fifo_pkg::PORT2_IDX, 2'b00};

  // ==========================================================
  // Ready status for the selected endpoint
  // Held low while the settle gap runs, so firmware never
  // takes a byte before it is valid
  assign sel_ok = st_q.sel != usb_fifo_pkg::SEL_RSVD;
  assign head   = sel_ok ? f_out_data[st_q.sel] : 8'h00;
  always_comb begin
    ready = 1'b0;
    if (st_q.req && sel_ok && st_q.gap == '0) begin
      ready = st_q.tx ? f_in_ready[st_q.sel]
                      : f_out_valid[st_q.sel];
    end
  end

  // Access allowed only on the selected port while ready
  assign ok = ready && port_hit[st_q.sel];

  // Status byte as seen by software
  always_comb begin
    status = 8'h00;
    status[usb_fifo_pkg::REQ_BIT]         = st_q.req;
    status[usb_fifo_pkg::TX_BIT]          = st_q.tx;
    status[usb_fifo_pkg::CLR_BIT]         = st_q.clr;
    status[usb_fifo_pkg::SEL_LO +: 2]     = st_q.sel;
    status[usb_fifo_pkg::SETUP_BIT]       = st_q.setup;
    status[usb_fifo_pkg::READY_BIT]       = ready;
    status[usb_fifo_pkg::ZLEN_BIT]        = st_q.zlen;
  end

  // Firmware strobes into the FIFOs, on the answered edge only
  always_comb begin
    fw_push = '0;
    fw_pop  = '0;
    if (fire && write_i && st_q.tx && ok) begin
      fw_push[st_q.sel] = 1'b1;
    end
    if (fire && read_i && !st_q.tx && ok && st_q.rok) begin
      fw_pop[st_q.sel] = 1'b1;
    end
  end

  // ==========================================================
  // Next state of the control register and bus answer
  always_comb begin
    st_d      = st_q;
    st_d.resp = bus_req && !st_q.resp;
    if (st_q.gap != '0) st_d.gap = st_q.gap - 1'b1;
    // Capture read data at the taking edge
    if (read_i && !st_q.resp) begin
      st_d.rok   = ok && !st_q.tx;
      st_d.rdata = ctrl_hit ? status
                 : (ok && !st_q.tx) ? head : 8'h00;
    end
    // Control write; flags are cleared by writing zero
    if (fire && write_i && ctrl_hit) begin
      st_d.req   = wd[usb_fifo_pkg::REQ_BIT];
      st_d.tx    = wd[usb_fifo_pkg::TX_BIT];
      st_d.clr   = wd[usb_fifo_pkg::CLR_BIT];
      st_d.sel   = wd[usb_fifo_pkg::SEL_LO +: 2];
      st_d.setup = st_q.setup && wd[usb_fifo_pkg::SETUP_BIT];
      st_d.zlen  = st_q.zlen && wd[usb_fifo_pkg::ZLEN_BIT];
      if (wd[usb_fifo_pkg::REQ_BIT] && !st_q.req) begin
        st_d.gap = usb_fifo_pkg::GAP_LOAD;
      end
    end
    // Each accepted data push or pop restarts the settle gap; a refused access leaves it running
    if (|fw_push || |fw_pop) st_d.gap = usb_fifo_pkg::GAP_LOAD;
    // Hardware set wins over a firmware clear
    if (setup_event_i) st_d.setup = 1'b1;
    if (zero_len_event_i) st_d.zlen = 1'b1;
    // Bus reset wipes the whole control register
    if (usb_reset_i) begin
      st_d.req   = 1'b0;
      st_d.tx    = 1'b0;
      st_d.clr   = 1'b0;
      st_d.sel   = usb_fifo_pkg::SEL_EP0;
      st_d.setup = 1'b0;
      st_d.zlen  = 1'b0;
      st_d.gap   = '0;
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (rst_i) st_q <= '0;
    else st_q <= st_d;
  end

  // ==========================================================
  // Per-endpoint FIFO with firmware or engine ownership
  for (genvar k = 0; k < NEP; k++) begin : g_ep
    logic             in_valid;
    logic [WIDTH-1:0] in_data;
    logic             out_ready;

    // Firmware owns the side that matches its direction
    assign own_push[k] = st_q.req && st_q.tx && st_q.sel == 2'(k);
    assign own_pop[k]  = st_q.req && !st_q.tx && st_q.sel == 2'(k);
    assign flush[k]    = st_q.clr && st_q.sel == 2'(k);
    assign in_valid  = own_push[k] ? fw_push[k] : eng_push_i[k].valid;
    assign in_data   = own_push[k] ? wd : eng_push_i[k].data;
    assign out_ready = own_pop[k] ? fw_pop[k] : eng_pop_ready_i[k];

    // Engine sees back-pressure while firmware owns a side
    // A flush blocks both sides, so the engine stalls with it
    assign eng_push_ready_o[k] = !own_push[k] && f_in_ready[k];
    assign eng_pop_o[k].valid  = !own_pop[k] && f_out_valid[k];
    assign eng_pop_o[k].data   = f_out_data[k];

    ep_byte_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH)
    ) u_fifo (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .flush_i     (flush[k]),
      .in_valid_i  (in_valid),
      .in_ready_o  (f_in_ready[k]),
      .in_data_i   (in_data),
      .out_valid_o (f_out_valid[k]),
      .out_ready_i (out_ready),
      .out_data_o  (f_out_data[k])
    );
  end

  // ==========================================================
  // Checks on the controller's own behaviour
  chk_bus_reset_clear: assert property (
    @(posedge clock_i) disable iff (rst_i)
    usb_reset_i |=> (status[5:0] == 6'h00 && !st_q.zlen))
    else $error("control register not cleared by bus reset");

  chk_clear_empties_fifo: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flush != '0 |=> (f_out_valid & $past(flush)) == '0)
    else $error("clear did not empty the selected FIFO");

  chk_reserved_select: assert property (
    @(posedge clock_i) disable iff (rst_i)
    st_q.sel == usb_fifo_pkg::SEL_RSVD |-> !ready && flush == '0)
    else $error("reserved select reached a FIFO");

  chk_setup_flag_sticky: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (st_q.setup && !usb_reset_i && !(fire && write_i && ctrl_hit))
    |=> st_q.setup)
    else $error("setup flag lost without firmware clear");

  chk_setup_flag_set: assert property (
    @(posedge clock_i) disable iff (rst_i)
    setup_event_i && !usb_reset_i |=> st_q.setup)
    else $error("setup event not recorded");

  chk_zero_flag_set: assert property (
    @(posedge clock_i) disable iff (rst_i)
    zero_len_event_i && !usb_reset_i |=> st_q.zlen)
    else $error("zero-length event not recorded");

  chk_ready_after_gap: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $rose(st_q.req) |-> !ready [*8] ##1 st_q.gap == GAP - 8)
    else $error("ready rose before the settle gap");

  chk_zero_len_status: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (st_q.zlen && st_q.req && !st_q.tx && st_q.sel == 2'h0
     && !st_q.setup && !st_q.clr && !f_out_valid[0])
    |-> status == 8'h81)
    else $error("zero-size packet status not 81h");

  chk_unready_port_idle: assert property (
    @(posedge clock_i) disable iff (rst_i)
    fire && any_port && !ready |-> fw_push == '0 && fw_pop == '0)
    else $error("data port moved FIFO while not ready");

  chk_bus_answer_time: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $rose(bus_req) |-> waitrequest_o ##1 !waitrequest_o)
    else $error("bus answer not one cycle after request");

  chk_gap_after_access: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (|fw_push || |fw_pop) && !usb_reset_i
    |=> st_q.gap == usb_fifo_pkg::GAP_LOAD && !ready)
    else $error("ready not held low after a data access");

  chk_clear_routes_select: assert property (
    @(posedge clock_i) disable iff (rst_i)
    st_q.clr && sel_ok |-> flush == (3'h1 << st_q.sel))
    else $error("clear flushed the wrong endpoint FIFO");

endmodule : usb_endpoint_fifo_access

// [usb_fifo_pkg.sv]
// Constants and carrier types for the endpoint FIFO access block
package usb_fifo_pkg;

  // ==========================================================
  // Register map (index is printed offset, byte address is x4)
  localparam int         ADDR_W     = 10;
  localparam logic [7:0] CTRL_IDX   = 8'h46;
  localparam logic [7:0] PORT0_IDX  = 8'h48;
  localparam logic [7:0] PORT1_IDX  = 8'h49;
  localparam logic [7:0] PORT2_IDX  = 8'h4A;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};

  // ==========================================================
  // Control register field positions
  localparam int REQ_BIT   = 0;
  localparam int TX_BIT    = 1;
  localparam int CLR_BIT   = 2;
  localparam int SEL_LO    = 3;
  localparam int SETUP_BIT = 5;
  localparam int READY_BIT = 6;
  localparam int ZLEN_BIT  = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // Endpoint select codes
  localparam logic [1:0] SEL_EP0  = 2'h0;
  localparam logic [1:0] SEL_EP1  = 2'h1;
  localparam logic [1:0] SEL_EP2  = 2'h2;
  localparam logic [1:0] SEL_RSVD = 2'h3;
  localparam int         NUM_EP   = 3;

  // ==========================================================
  // Timing: 2 us settle gap at a 40 ns clock, rounded up
  localparam int CLK_PERIOD_NS = 40;
  localparam int GAP_NS        = 2000;
  localparam int GAP_CYCLES =
    (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W = 6;
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(GAP_CYCLES);

  // ==========================================================
  // Byte stream carrier between engine and FIFOs
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } stream_type;

  // Whole state of the access controller
  typedef struct packed {
    logic             req;
    logic             tx;
    logic             clr;
    logic [1:0]       sel;
    logic             setup;
    logic             zlen;
    logic             resp;
    logic             rok;
    logic [7:0]       rdata;
    logic [GAP_W-1:0] gap;
  } ctrl_state_type;

endpackage : usb_fifo_pkg

// [usb_engine_model.sv]
// Behavioural engine model on the far side of the endpoint FIFOs
`timescale 1ns/1ns
// ==========
// Engine model
module usb_engine_model (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic                      stall_i,
  input  wire logic                      send_i,
  input  wire logic [1:0]                send_ep_i,
  input  wire logic [7:0]                send_data_i,
  input  wire logic [2:0]                push_ready_i,
  output usb_fifo_pkg::stream_type [2:0] push_o,
  output logic [2:0]                     pop_ready_o,
  output logic                           busy_o
);
  logic [1:0] ep_q;
  logic [7:0] data_q;
  logic [7:0] last_q;

  // One byte offered; an idle line shows the inverse of the last byte
  always_comb begin
    pop_ready_o = {3{~stall_i}};
    for (int k = 0; k < 3; k++) begin
      push_o[k].valid = busy_o && (ep_q == 2'(k));
      push_o[k].data  = push_o[k].valid ? data_q : ~last_q;
    end
  end

  // Byte held until its FIFO takes it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      last_q <= 8'h00;
    end else if (busy_o && push_ready_i[ep_q]) begin
      busy_o <= 1'b0;
      last_q <= data_q;
    end else if (send_i && !busy_o) begin
      busy_o <= 1'b1;
      ep_q   <= send_ep_i;
      data_q <= send_data_i;
    end
  end
endmodule : usb_engine_model

// [usb_endpoint_fifo_access_tb.sv]
// Self-checking bench for the endpoint FIFO access block
`timescale 1ns/1ns
// ==========
// Bench
module usb_endpoint_fifo_access_tb;
  localparam int DEPTH = 8;
  localparam int GAP   = usb_fifo_pkg::GAP_CYCLES + 2;
  logic        clock_i     = 1'b0;
  logic        rst_i       = 1'b1;
  logic        read_i      = 1'b0;
  logic        write_i     = 1'b0;
  logic        stall       = 1'b1;
  logic        send        = 1'b0;
  logic        busy;
  logic        waitrequest_o;
  logic [2:0]  ev          = 3'h0;
  logic [2:0]  push_rdy;
  logic [2:0]  pop_rdy;
  logic [1:0]  send_ep     = 2'h0;
  logic [7:0]  send_data   = 8'h00;
  logic [7:0]  b [DEPTH];
  logic [7:0]  x;
  logic [31:0] writedata_i = 32'h0;
  logic [31:0] readdata_o;
  logic [31:0] rd_q [$];
  logic [31:0] pop_q [$];
  int          miscompares = 0;
  int          n_tests     = 0;
  int          n;
  logic [usb_fifo_pkg::ADDR_W-1:0] address_i = '0;
  usb_fifo_pkg::stream_type [2:0]  push;
  usb_fifo_pkg::stream_type [2:0]  pop;

  // Block under test and the engine on its far side
  usb_endpoint_fifo_access #(.WIDTH(8), .DEPTH(DEPTH)) dut_u (
    .clock_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i,
    .readdata_o, .waitrequest_o, .usb_reset_i(ev[0]),
    .setup_event_i(ev[1]), .zero_len_event_i(ev[2]),
    .eng_push_i(push), .eng_push_ready_o(push_rdy),
    .eng_pop_o(pop), .eng_pop_ready_i(pop_rdy));
  usb_engine_model eng_u (
    .clock_i, .rst_i, .stall_i(stall), .send_i(send),
    .send_ep_i(send_ep), .send_data_i(send_data), .busy_o(busy),
    .push_ready_i(push_rdy), .push_o(push), .pop_ready_o(pop_rdy));

  // Clock
  initial begin
    forever #20 clock_i = ~clock_i;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // A used-up wait counts as a mismatch and ends the run
  task automatic limit(input int k);
    check(32'(k >= 200), 32'h0);
    if (k >= 200) summarize();
  endtask : limit

  // One Avalon-MM access, held until waitrequest is seen low
  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [7:0] d, input logic [7:0] e);
    int k = 0;
    if (!wr) rd_q.push_back({24'h000000, e});
    @(posedge clock_i);
    address_i   <= {idx, 2'b00};
    read_i      <= !wr;
    write_i     <= wr;
    writedata_i <= {24'h000000, d};
    do begin
      @(posedge clock_i);
      k++;
    end while (waitrequest_o && k < 200);
    limit(k);
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask : bus

  task automatic cw(input logic [7:0] d);
    bus(usb_fifo_pkg::CTRL_IDX, 1'b1, d, 8'h00);
  endtask : cw
  task automatic cr(input logic [7:0] e);
    bus(usb_fifo_pkg::CTRL_IDX, 1'b0, 8'h00, e);
  endtask : cr
  task automatic pr(input int p, input logic [7:0] e);
    bus(usb_fifo_pkg::PORT0_IDX + 8'(p), 1'b0, 8'h00, e);
  endtask : pr
  task automatic pw(input int p, input logic [7:0] d);
    bus(usb_fifo_pkg::PORT0_IDX + 8'(p), 1'b1, d, 8'h00);
  endtask : pw
  task automatic gap();
    repeat (GAP) @(posedge clock_i);
  endtask : gap

  // Engine hands one byte to FIFO p
  task automatic put(input logic [1:0] p, input logic [7:0] d);
    int k = 0;
    @(posedge clock_i);
    send      <= 1'b1;
    send_ep   <= p;
    send_data <= d;
    @(posedge clock_i);
    send <= 1'b0;
    do begin
      @(negedge clock_i);
      k++;
    end while (busy && k < 200);
    limit(k);
  endtask : put

  // One-cycle event pulse: bus reset, setup, zero length
  task automatic pulse(input logic [2:0] m);
    @(posedge clock_i);
    ev <= m;
    @(posedge clock_i);
    ev <= 3'h0;
  endtask : pulse

  // Answers and engine pops against the oldest note
  always @(posedge clock_i) begin
    if (read_i && !waitrequest_o) begin
      check(readdata_o, rd_q.pop_front());
    end
    for (int k = 0; k < 3; k++) begin
      if (pop[k].valid && pop_rdy[k]) begin
        check({24'h000000, pop[k].data}, pop_q.pop_front());
      end
    end
  end

  // Main sequence
  initial begin
    void'($urandom(43));
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    cr(8'h00);
    bus(8'h47, 1'b1, 8'hFF, 8'h00);
    bus(8'h47, 1'b0, 8'h00, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      b[i] = 8'($urandom);
      put(2'h0, b[i]);
    end
    pr(0, 8'h00);
    cw(8'h00);
    cw(8'h01);
    gap();
    cr(8'h41);
    for (int i = 0; i < 3; i++) begin
      pr(0, b[i]);
      pr(0, 8'h00);
      gap();
    end
    cr(8'h01);
    cw(8'h03);
    cw(8'h02);
    cr(8'h02);
    $display("test read fifo done");
    cw(8'h0A);
    cw(8'h0B);
    gap();
    cr(8'h4B);
    for (int i = 0; i < DEPTH; i++) begin
      b[i] = 8'($urandom);
      pop_q.push_back({24'h000000, b[i]});
      pw(1, b[i]);
      pw(1, 8'h5A);
      gap();
    end
    cr(8'h0B);
    cw(8'h09);
    cw(8'h08);
    stall <= 1'b0;
    n = 0;
    while (pop_q.size() != 0 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    stall <= 1'b1;
    limit(n);
    $display("test write fifo done");
    for (int i = 0; i < DEPTH; i++) begin
      put(2'h1, 8'($urandom));
    end
    cw(8'h0A);
    cw(8'h0B);
    gap();
    cr(8'h0B);
    cw(8'h0F);
    cw(8'h0D);
    cw(8'h08);
    cw(8'h09);
    gap();
    cr(8'h09);
    cw(8'h08);
    $display("test zero send done");
    put(2'h2, 8'h3C);
    x = 8'($urandom);
    put(2'h0, x);
    cw(8'h14);
    cw(8'h10);
    cw(8'h11);
    gap();
    cr(8'h11);
    cw(8'h18);
    cw(8'h19);
    gap();
    cr(8'h19);
    cw(8'h00);
    cw(8'h01);
    gap();
    cr(8'h41);
    pr(2, 8'h00);
    pr(0, x);
    cw(8'h03);
    cw(8'h02);
    $display("test clear select done");
    pulse(3'h2);
    cr(8'h22);
    cw(8'h20);
    cr(8'h20);
    cw(8'h00);
    cr(8'h00);
    cw(8'h01);
    pulse(3'h4);
    gap();
    cr(8'h81);
    pr(0, 8'h00);
    cw(8'h81);
    cr(8'h81);
    cw(8'h01);
    cr(8'h01);
    pulse(3'h2);
    cw(8'h3B);
    pulse(3'h1);
    cr(8'h00);
    $display("test flags done");
    summarize();
  end
endmodule : usb_endpoint_fifo_access_tb
